// file: core/xgrx_top.sv
// Receive parallel output port, four lanes, double data rate
`timescale 1ns/1ps
`include "xgrx_consts.svh"
// What this block does
// [RULE1] Lane A's eight data bits hold steady across both edges of lane A's clock.
// [RULE2] With coding off, lane A bit 8 is the raw ninth code bit.
// [RULE3] With coding on, lane A bit 8 is high for a valid K-character.
// [RULE4] With coding off, lane A bit 9 is the raw tenth code bit on both edges.
// [RULE5] With coding on, lane A bit 9 is high on disparity or invalid-code error.
// [RULE6] With lane sync low, lanes B to D follow their own recovered clocks.
// [RULE7] With lane sync high, lanes B to D follow lane A's clock.
// [RULE8] Lanes B to D bit 8 is raw ninth bit or K flag by coding select.
// [RULE9] Lanes B to D bit 9 is raw tenth bit or error flag by coding select.
// [RULE10] With lane sync high, lane A's clock times all four lanes.
// [RULE11] With lane sync high, clock outputs B to D copy lane A's clock.
// [RULE12] The receiver captures all ten bits on both edges and reads bits 8, 9 by coding.
module xgrx_top #(
  parameter int NUM_LANES = `XGRX_NUM_LANES,
  parameter int CLK_LAG   = `XGRX_CLK_LAG
)
(
  input  wire logic                                      clk_in,
  input  wire logic                                      rstn_in,
  input  wire logic [NUM_LANES-1:0]                      rx_recov_clk_in,
  input  wire logic                                      lane_sync_select_in,
  input  wire logic                                      code_select_in,
  input  wire logic [NUM_LANES-1:0][`XGRX_CODE_W-1:0]    rx_code_group_in,
  input  wire logic [NUM_LANES-1:0][`XGRX_BYTE_W-1:0]    rx_dec_byte_in,
  input  wire logic [NUM_LANES-1:0]                      rx_dec_k_in,
  input  wire logic [NUM_LANES-1:0]                      rx_dec_err_in,
  output logic      [`XGRX_BYTE_W-1:0]                   rx_lane_a_bus_out,
  output logic                                           rx_lane_a_bit8_kflag_out,
  output logic                                           rx_lane_a_bit9_errflag_out,
  output logic      [`XGRX_BYTE_W-1:0]                   rx_lane_b_bus_out,
  output logic                                           rx_lane_b_bit8_out,
  output logic                                           rx_lane_b_bit9_out,
  output logic      [`XGRX_BYTE_W-1:0]                   rx_lane_c_bus_out,
  output logic                                           rx_lane_c_bit8_out,
  output logic                                           rx_lane_c_bit9_out,
  output logic      [`XGRX_BYTE_W-1:0]                   rx_lane_d_bus_out,
  output logic                                           rx_lane_d_bit8_out,
  output logic                                           rx_lane_d_bit9_out,
  output logic                                           rx_clk_lane_a_out,
  output logic                                           rx_clk_lane_b_out,
  output logic                                           rx_clk_lane_c_out,
  output logic                                           rx_clk_lane_d_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [NUM_LANES-1:0] clk_meta;
  logic [NUM_LANES-1:0] clk_sync;
  logic                 psel_meta;
  logic                 psel_sync;
  logic                 code_meta;
  logic                 code_sync;
  logic [NUM_LANES-1:0] sel_clk;
  logic [NUM_LANES-1:0] sel_clk_prev;
  logic [NUM_LANES-1:0] sel_edge;

  // Link clocks come from other domains, so two flops before any use
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      clk_meta <= '0;
      clk_sync <= '0;
    end
    else
    begin
      clk_meta <= rx_recov_clk_in;
      clk_sync <= clk_meta;
    end
  end

  // Select pins are static straps in use, but still cross in as pins
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      psel_meta <= 1'h0;
      psel_sync <= 1'h0;
      code_meta <= 1'h0;
      code_sync <= 1'h0;
    end
    else
    begin
      psel_meta <= lane_sync_select_in;
      psel_sync <= psel_meta;
      code_meta <= code_select_in;
      code_sync <= code_meta;
    end
  end

  // Last selected level, so either polarity shows as an edge
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      sel_clk_prev <= '0;
    end
    else
    begin
      sel_clk_prev <= sel_clk;
    end
  end

  // ****************************************
  // Clock selection and edge finding
  // ****************************************
  // A select change can show one extra edge; the partner is expected to
  // change lane sync only while the link is idle.
  assign sel_clk[`XGRX_LANE_A] = clk_sync[`XGRX_LANE_A];

  genvar g;
  generate
    for (g = `XGRX_LANE_B; g < NUM_LANES; g++)
    begin : g_sel
      assign sel_clk[g] = psel_sync ? clk_sync[`XGRX_LANE_A] : clk_sync[g]; // [RULE10] [RULE7] [RULE6]
    end
  endgenerate

  assign sel_edge = sel_clk ^ sel_clk_prev;

  // ****************************************
  // Lanes
  // ****************************************
  xgrx_lane_if lane_if [NUM_LANES] ();

  generate
    for (g = 0; g < NUM_LANES; g++)
    begin : g_lane
      assign lane_if[g].clk_level   = sel_clk[g];
      assign lane_if[g].clk_edge    = sel_edge[g];
      assign lane_if[g].code_select = code_sync;
      assign lane_if[g].raw_code    = rx_code_group_in[g];
      assign lane_if[g].dec_byte    = rx_dec_byte_in[g];
      assign lane_if[g].dec_k       = rx_dec_k_in[g];
      assign lane_if[g].dec_err     = rx_dec_err_in[g];

      xgrx_lane #(
        .CLK_LAG (CLK_LAG)
      ) u_lane (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .lif     (lane_if[g])
      );
    end
  endgenerate

  // ****************************************
  // Pin mapping, all straight from lane flops
  // ****************************************
  assign rx_lane_a_bus_out          = lane_if[`XGRX_LANE_A].lane_word[`XGRX_BYTE_W-1:0];
  assign rx_lane_a_bit8_kflag_out   = lane_if[`XGRX_LANE_A].lane_word[`XGRX_KFLAG_BIT];
  assign rx_lane_a_bit9_errflag_out = lane_if[`XGRX_LANE_A].lane_word[`XGRX_ERR_BIT];
  assign rx_lane_b_bus_out          = lane_if[`XGRX_LANE_B].lane_word[`XGRX_BYTE_W-1:0];
  assign rx_lane_b_bit8_out         = lane_if[`XGRX_LANE_B].lane_word[`XGRX_KFLAG_BIT];
  assign rx_lane_b_bit9_out         = lane_if[`XGRX_LANE_B].lane_word[`XGRX_ERR_BIT];
  assign rx_lane_c_bus_out          = lane_if[`XGRX_LANE_C].lane_word[`XGRX_BYTE_W-1:0];
  assign rx_lane_c_bit8_out         = lane_if[`XGRX_LANE_C].lane_word[`XGRX_KFLAG_BIT];
  assign rx_lane_c_bit9_out         = lane_if[`XGRX_LANE_C].lane_word[`XGRX_ERR_BIT];
  assign rx_lane_d_bus_out          = lane_if[`XGRX_LANE_D].lane_word[`XGRX_BYTE_W-1:0];
  assign rx_lane_d_bit8_out         = lane_if[`XGRX_LANE_D].lane_word[`XGRX_KFLAG_BIT];
  assign rx_lane_d_bit9_out         = lane_if[`XGRX_LANE_D].lane_word[`XGRX_ERR_BIT];
  assign rx_clk_lane_a_out          = lane_if[`XGRX_LANE_A].lane_clk;
  assign rx_clk_lane_b_out          = lane_if[`XGRX_LANE_B].lane_clk;
  assign rx_clk_lane_c_out          = lane_if[`XGRX_LANE_C].lane_clk;
  assign rx_clk_lane_d_out          = lane_if[`XGRX_LANE_D].lane_clk;

endmodule

// file: pkg/xgrx_consts.svh
// Constants for the receive parallel output block
`ifndef XGRX_CONSTS_SVH
`define XGRX_CONSTS_SVH

`define XGRX_NUM_LANES 4
`define XGRX_CODE_W    10
`define XGRX_BYTE_W    8
`define XGRX_KFLAG_BIT 8
`define XGRX_ERR_BIT   9
`define XGRX_LANE_A    0
`define XGRX_LANE_B    1
`define XGRX_LANE_C    2
`define XGRX_LANE_D    3
`define XGRX_CLK_LAG   3

`endif

// file: pkg/xgrx_pkg.sv
// Types shared by the receive parallel output block
`include "xgrx_consts.svh"
package xgrx_pkg;
  typedef logic [`XGRX_CODE_W-1:0] xgrx_word_t;
  typedef logic [`XGRX_BYTE_W-1:0] xgrx_byte_t;
endpackage

// file: pkg/xgrx_lane_if.sv
// Signals between the top and one output lane
`timescale 1ns/1ps
interface xgrx_lane_if;
  logic                 clk_level;
  logic                 clk_edge;
  logic                 code_select;
  xgrx_pkg::xgrx_word_t raw_code;
  xgrx_pkg::xgrx_byte_t dec_byte;
  logic                 dec_k;
  logic                 dec_err;
  xgrx_pkg::xgrx_word_t lane_word;
  logic                 lane_clk;

  modport lane
  (
    input  clk_level,
    input  clk_edge,
    input  code_select,
    input  raw_code,
    input  dec_byte,
    input  dec_k,
    input  dec_err,
    output lane_word,
    output lane_clk
  );

  modport top
  (
    output clk_level,
    output clk_edge,
    output code_select,
    output raw_code,
    output dec_byte,
    output dec_k,
    output dec_err,
    input  lane_word,
    input  lane_clk
  );
endinterface

// file: core/xgrx_lane.sv
// One receive lane: word select, edge-timed capture and clock regeneration
`timescale 1ns/1ps
`include "xgrx_consts.svh"
module xgrx_lane #(
  parameter int CLK_LAG = `XGRX_CLK_LAG
)
(
  input  wire logic   clk_in,
  input  wire logic   rstn_in,
  xgrx_lane_if.lane   lif
);

  // ****************************************
  // Word selection
  // ****************************************
  xgrx_pkg::xgrx_word_t coded_word;
  xgrx_pkg::xgrx_word_t next_word;
  xgrx_pkg::xgrx_word_t word;
  logic [CLK_LAG-1:0]   clk_pipe;

  assign coded_word = {lif.dec_err, lif.dec_k, lif.dec_byte}; // [RULE3] [RULE5] [RULE8] [RULE9]
  assign next_word  = lif.code_select ? coded_word : lif.raw_code; // [RULE2] [RULE4]

  // ****************************************
  // Capture and clock out
  // ****************************************
  // Clock out lags the data change so each edge lands mid-window
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      word     <= '0;
      clk_pipe <= '0;
    end
    else
    begin
      if (lif.clk_edge)
      begin
        word <= next_word; // [RULE1] [RULE6] [RULE7]
      end
      clk_pipe <= {clk_pipe[CLK_LAG-2:0], lif.clk_level};
    end
  end

  assign lif.lane_word = word;
  assign lif.lane_clk  = clk_pipe[CLK_LAG-1]; // [RULE11]

endmodule

// file: dv/xgrx_monitor.sv
// Concurrent checks on the receive parallel output port
`timescale 1ns/1ps
module xgrx_monitor #(parameter int NUM_LANES = 4)
(
  input wire logic                      clk_in,
  input wire logic                      rstn_in,
  input wire logic                      lane_sync_select_in,
  input wire logic                      code_select_in,
  input wire logic [NUM_LANES-1:0][9:0] rx_code_group_in,
  input wire logic [NUM_LANES-1:0][7:0] rx_dec_byte_in,
  input wire logic [NUM_LANES-1:0]      rx_dec_k_in,
  input wire logic [NUM_LANES-1:0]      rx_dec_err_in,
  input wire logic [7:0]                rx_lane_a_bus_out,
  input wire logic                      rx_lane_a_bit8_kflag_out,
  input wire logic                      rx_lane_a_bit9_errflag_out,
  input wire logic [7:0]                rx_lane_b_bus_out,
  input wire logic                      rx_lane_b_bit8_out,
  input wire logic                      rx_lane_b_bit9_out,
  input wire logic [7:0]                rx_lane_d_bus_out,
  input wire logic                      rx_lane_d_bit8_out,
  input wire logic                      rx_lane_d_bit9_out,
  input wire logic                      rx_clk_lane_a_out,
  input wire logic                      rx_clk_lane_b_out,
  input wire logic                      rx_clk_lane_c_out,
  input wire logic                      rx_clk_lane_d_out
);
  wire [9:0] a_w = {rx_lane_a_bit9_errflag_out, rx_lane_a_bit8_kflag_out, rx_lane_a_bus_out};
  wire [9:0] b_w = {rx_lane_b_bit9_out, rx_lane_b_bit8_out, rx_lane_b_bus_out};
  wire [9:0] d_w = {rx_lane_d_bit9_out, rx_lane_d_bit8_out, rx_lane_d_bus_out};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Selects must have settled, or a switch-over capture muddles the relation
  sequence a_edge_s; $changed(rx_clk_lane_a_out); endsequence
  sequence coded_s; code_select_in [*6]; endsequence
  sequence raw_s; (!code_select_in) [*6]; endsequence
  sequence coded_sync_s; (code_select_in && lane_sync_select_in) [*8]; endsequence
  sequence raw_own_s; (!code_select_in && !lane_sync_select_in) [*8]; endsequence
  coded_word_a: assert property (coded_s ##0 a_edge_s |->
    a_w == {$past(rx_dec_err_in[0], 2), $past(rx_dec_k_in[0], 2), $past(rx_dec_byte_in[0], 2)})
    else $error("lane a coded word wrong");
  raw_word_a: assert property (raw_s ##0 a_edge_s |->
    a_w == $past(rx_code_group_in[0], 2)) else $error("lane a raw word wrong");
  synced_word_a: assert property (coded_sync_s ##0
    $changed(rx_clk_lane_b_out) |-> b_w == {$past(rx_dec_err_in[1], 2),
    $past(rx_dec_k_in[1], 2), $past(rx_dec_byte_in[1], 2)}) else $error("lane b word wrong");
  own_word_a: assert property (raw_own_s ##0
    $changed(rx_clk_lane_d_out) |-> d_w == $past(rx_code_group_in[3], 2))
    else $error("lane d word wrong");
  clock_copy_a: assert property (lane_sync_select_in [*8] |->
    rx_clk_lane_b_out == rx_clk_lane_a_out && rx_clk_lane_c_out == rx_clk_lane_a_out &&
    rx_clk_lane_d_out == rx_clk_lane_a_out) else $error("lane clocks differ");
  word_hold_a: assert property (a_edge_s |-> $stable(a_w) ##1 $stable(a_w))
    else $error("lane a word moved at edge");
  edge_follow_a: assert property ($changed(a_w) |-> ##[1:2] a_edge_s)
    else $error("lane a word without edge");
  reset_zero_a: assert property (disable iff (1'b0) !rstn_in |=>
    a_w == 10'h000 && !rx_clk_lane_a_out) else $error("lane a not cleared");
endmodule

bind xgrx_top xgrx_monitor #(.NUM_LANES(NUM_LANES)) mon (.clk_in, .rstn_in,
  .lane_sync_select_in, .code_select_in, .rx_code_group_in, .rx_dec_byte_in, .rx_dec_k_in,
  .rx_dec_err_in, .rx_lane_a_bus_out, .rx_lane_a_bit8_kflag_out, .rx_lane_a_bit9_errflag_out,
  .rx_lane_b_bus_out, .rx_lane_b_bit8_out, .rx_lane_b_bit9_out, .rx_lane_d_bus_out,
  .rx_lane_d_bit8_out, .rx_lane_d_bit9_out, .rx_clk_lane_a_out, .rx_clk_lane_b_out,
  .rx_clk_lane_c_out, .rx_clk_lane_d_out);

// file: dv/xgrx_mac_model.sv
// Far-end receiver model: takes each lane's word on both edges of its clock
`timescale 1ns/1ps
module xgrx_mac_model
(
  input  wire logic            clk_in,
  input  wire logic [3:0]      lclk_in,
  input  wire logic [3:0][9:0] word_in,
  output logic      [3:0][9:0] got_out
);
  logic [3:0] prev;
  always_ff @(posedge clk_in)
  begin
    prev <= lclk_in;
    for (int i = 0; i < 4; i++)
      if (lclk_in[i] != prev[i]) got_out[i] <= word_in[i];
  end
endmodule

// file: dv/tb.sv
// Self-checking bench for the receive parallel output port
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h seen %h", n, e, s); end end
module tb;
  logic            clk_in = 1'b0, rstn_in = 1'b0, sync = 1'b0, code = 1'b0;
  logic [3:0]      rclk = 4'h0, k = 4'h0, err = 4'h0;
  logic [3:0][9:0] cg = '0, exp_w;
  logic [3:0][7:0] db = '0;
  wire  [3:0]      lclk;
  wire  [3:0][9:0] word, got;
  int              n_fail = 0, samples_checked = 0, nstep = 0, cyc = 0;
  xgrx_top dut (.clk_in, .rstn_in, .rx_recov_clk_in(rclk), .lane_sync_select_in(sync),
    .code_select_in(code), .rx_code_group_in(cg), .rx_dec_byte_in(db), .rx_dec_k_in(k),
    .rx_dec_err_in(err), .rx_lane_a_bus_out(word[0][7:0]), .rx_lane_a_bit8_kflag_out(word[0][8]),
    .rx_lane_a_bit9_errflag_out(word[0][9]), .rx_lane_b_bus_out(word[1][7:0]),
    .rx_lane_b_bit8_out(word[1][8]), .rx_lane_b_bit9_out(word[1][9]),
    .rx_lane_c_bus_out(word[2][7:0]), .rx_lane_c_bit8_out(word[2][8]),
    .rx_lane_c_bit9_out(word[2][9]), .rx_lane_d_bus_out(word[3][7:0]),
    .rx_lane_d_bit8_out(word[3][8]), .rx_lane_d_bit9_out(word[3][9]),
    .rx_clk_lane_a_out(lclk[0]), .rx_clk_lane_b_out(lclk[1]), .rx_clk_lane_c_out(lclk[2]),
    .rx_clk_lane_d_out(lclk[3]));
  xgrx_mac_model mac (.clk_in, .lclk_in(lclk), .word_in(word), .got_out(got));
  initial forever #20 clk_in = ~clk_in;
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_in)
    if (++cyc > 2000)
    begin
      n_fail++;
      finish_test();
    end
  function automatic logic [9:0] expw(int i);
    return code ? {err[i], k[i], db[i]} : cg[i];
  endfunction
  // Half a link period is four cycles, so a 320 ns link clock when every lane toggles
  task automatic step(logic [3:0] m, logic hi);
    logic [3:0][9:0] nxt;
    @(negedge clk_in);
    rclk ^= m;
    {cg, db} = 72'({$urandom, $urandom, $urandom});
    {k, err} = hi ? 8'hff : 8'($urandom);
    for (int i = 0; i < 4; i++)
      nxt[i] = m[(i == 0 || !sync) ? i : 0] ? expw(i) : exp_w[i];
    repeat (3) @(negedge clk_in);
    for (int i = 0; i < 4; i++)
      if (nstep > 0) `CHK("lane word", exp_w[i], got[i])
    nstep++;
    exp_w = nxt;
  endtask
  // A select change may add one capture, so the next word is not judged
  task automatic mode(logic [1:0] v);
    @(negedge clk_in);
    {sync, code} = v;
    nstep = 0;
    repeat (8) @(negedge clk_in);
  endtask
  // Every output must read zero while reset is held
  task automatic reset_for(int n);
    rstn_in = 1'b0;
    repeat (n) @(negedge clk_in);
    `CHK("reset word", 40'h0, word)
    `CHK("reset clock", 4'h0, lclk)
    rstn_in = 1'b1;
    nstep = 0;
  endtask
  initial
  begin
    void'($urandom(32'h2cb225f1));
    reset_for(12);
    for (int md = 0; md < 4; md++)
    begin
      mode(2'(md));
      step(4'hf, 1'b0);
      for (int j = 0; j < 24; j++)
        step(j % 5 == 0 ? 4'h1 : 4'($urandom), j % 7 == 3);
    end
    // Park every link clock low first, so release shows no false edge
    step(rclk, 1'b0);
    repeat (8) @(negedge clk_in);
    reset_for(4);
    for (int j = 0; j < 8; j++)
      step(4'($urandom), j == 2);
    finish_test();
  end
endmodule
